/* File: src/settings_download_command_parser.v */
/*
 * Settings download command parser: takes a byte stream of receive
 * buffer command frames, stages each frame, and on its last byte
 * commits communications settings or counter presets.
 * Assumes the byte stream comes from logic on clk_sys, with a flag
 * marking the first byte of each frame, and an AXI4-Lite master.
 */
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "settings_parser_map.vh"

// Operation
// - Subcommand 1 comms, 2 counters, others not loaded.
// - Password, spare, command byte, checksum high then low.
// - Code 0xa1 routes to communications decoder.
// - Code 0xa2 routes to counter preset loader.
// - Sixteen-bit fields arrive high byte first.
// - Config bits 0-3 select line rate.
// - Config bits 4-5 select parity.
// - Config bit 6 selects seven or eight bits.
// - Config bit 7 selects one or two stops.
// - Unit address, then front, rear, RS485 configs.
// - Time-code byte: off, centisecond or millisecond.
// - Ten auxiliary parameter bytes stored.
// - Auxiliary mode byte bits enable modes 1-8.
// - Three phase duty accumulators loaded.
// - Trip and breaker operation counters loaded.
// - Six reclose counters loaded in order.
// - Per-phase trip counters loaded on variants only.
module settings_download_command_parser (
  // Clock, reset and enable
  input  wire                        clk_sys,
  input  wire                        rst_b,
  input  wire                        clk_en,
  // Received byte stream
  input  wire [7:0]                  rx_data,
  input  wire                        rx_first,
  input  wire                        rx_valid,
  output wire                        rx_ready,
  // Decoded communications settings
  output reg  [15:0]                 unit_address,
  output reg  [16*`N_PORTS-1:0]      port_baud,
  output reg  [2*`N_PORTS-1:0]       port_parity,
  output reg  [`N_PORTS-1:0]         port_eight_bits,
  output reg  [`N_PORTS-1:0]         port_two_stop,
  output reg                         timecode_enable,
  output reg                         timecode_centisecond_mode,
  output reg  [8*`N_AUX-1:0]         aux_param,
  output reg  [7:0]                  aux_mode_enable,
  output reg                         comms_load,
  // Counter presets
  output reg  [16*`N_COUNTERS-1:0]   counter_preset,
  output reg                         counter_load,
  // AXI4-Lite slave
  input  wire [7:0]                  s_axi_awaddr,
  input  wire                        s_axi_awvalid,
  output wire                        s_axi_awready,
  input  wire [31:0]                 s_axi_wdata,
  input  wire [3:0]                  s_axi_wstrb,
  input  wire                        s_axi_wvalid,
  output wire                        s_axi_wready,
  output reg  [1:0]                  s_axi_bresp,
  output reg                         s_axi_bvalid,
  input  wire                        s_axi_bready,
  input  wire [7:0]                  s_axi_araddr,
  input  wire                        s_axi_arvalid,
  output wire                        s_axi_arready,
  output reg  [31:0]                 s_axi_rdata,
  output reg  [1:0]                  s_axi_rresp,
  output reg                         s_axi_rvalid,
  input  wire                        s_axi_rready
);

  // ****************************************************************
  // Two-entry input buffer
  // ****************************************************************
  reg  [8:0] buf_word [0:1];
  reg        buf_rd;
  reg  [1:0] buf_count;
  wire       buf_out_valid = (buf_count != 2'd0);
  wire       parse_ready;
  wire       buf_push = rx_valid && rx_ready;
  wire       buf_pop  = buf_out_valid && parse_ready;
  wire [8:0] buf_head = buf_word[buf_rd];

  // A full buffer holds its words until the parser drains one.
  assign rx_ready = clk_en && (buf_count != 2'd2);

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      buf_rd    <= 1'b0;
      buf_count <= 2'd0;
    end else if (clk_en) begin
      if (buf_push)
        buf_word[buf_rd ^ buf_count[0]] <= {rx_first, rx_data};
      if (buf_pop)
        buf_rd <= ~buf_rd;
      if (buf_push && !buf_pop)
        buf_count <= buf_count + 2'd1;
      else if (buf_pop && !buf_push)
        buf_count <= buf_count - 2'd1;
    end
  end

  // ****************************************************************
  // Frame staging
  // ****************************************************************
  reg  [7:0]  stage [0:47];
  reg  [5:0]  idx;
  reg         active;
  reg  [3:0]  sub;
  reg         commit_pend;
  reg  [1:0]  ctrl;
  reg  [3:0]  status;
  wire        parser_on   = ctrl[0];
  wire        variant_on  = ctrl[1];
  wire [7:0]  byte_in     = buf_head[7:0];
  wire        first_in    = buf_head[8];
  wire [5:0]  last_idx    = (sub == `SUB_COUNTERS) ? `COUNTERS_LAST :
                            `COMMS_LAST;

  // The commit cycle stalls the buffer so a following frame
  // cannot overwrite staged bytes before they are used.
  assign parse_ready = !commit_pend;

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      idx         <= 6'd0;
      active      <= 1'b0;
      sub         <= `SUB_REPEAT;
      commit_pend <= 1'b0;
    end else if (clk_en) begin
      commit_pend <= 1'b0;
      if (buf_pop) begin
        if (first_in) begin
          stage[0] <= byte_in;
          idx      <= 6'd1;
          active   <= parser_on;
        end else if (active) begin
          stage[idx] <= byte_in;
          idx        <= idx + 6'd1;
          if (idx == `POS_CMD) begin
            sub <= byte_in[3:0];
            if (byte_in[7:4] != `CMD_FAMILY ||
                (byte_in[3:0] != `SUB_COMMS &&
                 byte_in[3:0] != `SUB_COUNTERS))
              active <= 1'b0;
          end else if (idx > `POS_CMD && idx == last_idx) begin
            active      <= 1'b0;
            commit_pend <= 1'b1;
          end
        end
      end
    end
  end

  // ****************************************************************
  // Field extraction
  // ****************************************************************
  wire [16*`N_COUNTERS-1:0] cnt_field;
  wire [`N_COUNTERS-1:0]    cnt_over;
  wire [16*`N_PORTS-1:0]    next_baud;
  genvar g;

  generate
    for (g = 0; g < `N_COUNTERS; g = g + 1) begin : g_cnt
      assign cnt_field[16*g +: 16] = {stage[`POS_CNT0 + 2*g],
                                      stage[`POS_CNT0 + 2*g + 1]};
      if (g >= `FIRST_VARIANT_CNT) begin : g_var
        assign cnt_over[g] = variant_on &&
                             (cnt_field[16*g +: 16] > `PRESET_MAX);
      end else begin : g_std
        assign cnt_over[g] = (cnt_field[16*g +: 16] > `PRESET_MAX);
      end
    end
    for (g = 0; g < `N_PORTS; g = g + 1) begin : g_port
      assign next_baud[16*g +: 16] =
        rate_of(stage[`POS_PORT0 + g][`CFG_RATE_HI:`CFG_RATE_LO]);
    end
  endgenerate

  // Unlisted rate codes give zero, which a user reads as invalid.
  function [15:0] rate_of;
    input [3:0] code;
    begin
      case (code)
        4'h0:    rate_of = 16'd300;
        4'h1:    rate_of = 16'd1200;
        4'h2:    rate_of = 16'd2400;
        4'h3:    rate_of = 16'd4800;
        4'h4:    rate_of = 16'd9600;
        4'h5:    rate_of = 16'd19200;
        4'h6:    rate_of = 16'd38400;
        default: rate_of = 16'd0;
      endcase
    end
  endfunction

  wire is_comms   = (sub == `SUB_COMMS);
  wire is_counter = (sub == `SUB_COUNTERS);
  wire reject     = is_counter && (cnt_over != {`N_COUNTERS{1'b0}});
  wire [15:0] rx_checksum = {stage[last_idx - 6'd1], stage[last_idx]};
  wire [31:0] rx_password = {stage[0], stage[1], stage[2], stage[3]};

  // ****************************************************************
  // Commit of decoded settings
  // ****************************************************************
  reg [31:0] password;
  reg [15:0] checksum;
  reg [7:0]  port_cfg_raw [0:`N_PORTS-1];
  reg [7:0]  timecode_raw;
  integer    i;

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      unit_address              <= 16'h0000;
      port_baud                 <= {(16*`N_PORTS){1'b0}};
      port_parity               <= {(2*`N_PORTS){1'b0}};
      port_eight_bits           <= {`N_PORTS{1'b0}};
      port_two_stop             <= {`N_PORTS{1'b0}};
      timecode_enable           <= 1'b0;
      timecode_centisecond_mode <= 1'b0;
      timecode_raw              <= 8'h00;
      aux_param                 <= {(8*`N_AUX){1'b0}};
      aux_mode_enable           <= 8'h00;
      counter_preset            <= {(16*`N_COUNTERS){1'b0}};
      comms_load                <= 1'b0;
      counter_load              <= 1'b0;
      password                  <= 32'h0000_0000;
      checksum                  <= 16'h0000;
      for (i = 0; i < `N_PORTS; i = i + 1)
        port_cfg_raw[i] <= 8'h00;
    end else if (clk_en) begin
      comms_load   <= 1'b0;
      counter_load <= 1'b0;
      if (commit_pend) begin
        password <= rx_password;
        checksum <= rx_checksum;
      end
      // Spare bytes are staged but never read.
      if (commit_pend && is_comms) begin
        comms_load   <= 1'b1;
        unit_address <= {stage[`POS_ADDR_HI], stage[`POS_ADDR_LO]};
        port_baud    <= next_baud;
        for (i = 0; i < `N_PORTS; i = i + 1) begin
          port_cfg_raw[i] <= stage[`POS_PORT0 + i];
          port_parity[2*i +: 2] <=
            stage[`POS_PORT0 + i][`CFG_PAR_HI:`CFG_PAR_LO];
          port_eight_bits[i] <= stage[`POS_PORT0 + i][`CFG_DATA_BIT];
          port_two_stop[i]   <= stage[`POS_PORT0 + i][`CFG_STOP_BIT];
        end
        timecode_raw <= stage[`POS_TIMECODE];
        timecode_enable <= (stage[`POS_TIMECODE] == `TC_CENTI) ||
                           (stage[`POS_TIMECODE] == `TC_MILLI);
        timecode_centisecond_mode <= (stage[`POS_TIMECODE] == `TC_CENTI);
        for (i = 0; i < `N_AUX; i = i + 1)
          aux_param[8*i +: 8] <= stage[`POS_AUX0 + i];
        aux_mode_enable <= stage[`POS_AUX_MODE];
      end
      if (commit_pend && is_counter && !reject) begin
        counter_load <= 1'b1;
        // Accumulators 0-2, trip and breaker 3-4, reclose 5-10.
        counter_preset[16*`FIRST_VARIANT_CNT-1:0] <=
          cnt_field[16*`FIRST_VARIANT_CNT-1:0];
        if (variant_on)
          counter_preset[16*`N_COUNTERS-1:16*`FIRST_VARIANT_CNT] <=
            cnt_field[16*`N_COUNTERS-1:16*`FIRST_VARIANT_CNT];
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite register file
  // ****************************************************************
  wire wr_go = clk_en && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  wire rd_go = clk_en && s_axi_arvalid && !s_axi_rvalid;
  wire [3:0] status_set = {
    buf_pop && active && idx == `POS_CMD && (byte_in[7:4] != `CMD_FAMILY ||
      (byte_in[3:0] != `SUB_COMMS && byte_in[3:0] != `SUB_COUNTERS)),
    commit_pend && reject,
    commit_pend && is_counter && !reject,
    commit_pend && is_comms};
  wire [3:0] status_clr = (wr_go && s_axi_awaddr == `REG_STATUS &&
                           s_axi_wstrb[0]) ? s_axi_wdata[3:0] : 4'h0;

  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = rd_go;

  reg [31:0] rd_word;
  reg        rd_hit;
  always @* begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      `REG_CTRL:      rd_word = {30'h0, ctrl};
      `REG_STATUS:    rd_word = {28'h0, status};
      `REG_PASSWORD:  rd_word = password;
      `REG_CHECKSUM:  rd_word = {16'h0, checksum};
      `REG_UNIT_ADDR: rd_word = {16'h0, unit_address};
      `REG_PORT_CFG:  rd_word = {timecode_raw, port_cfg_raw[2],
                                 port_cfg_raw[1], port_cfg_raw[0]};
      `REG_AUX_MODE:  rd_word = {24'h0, aux_mode_enable};
      `REG_AUX0:      rd_word = aux_param[31:0];
      `REG_AUX1:      rd_word = aux_param[63:32];
      `REG_AUX2:      rd_word = {16'h0, aux_param[79:64]};
      default: begin
        if (s_axi_araddr >= `REG_CNT_BASE &&
            s_axi_araddr <= `REG_CNT_LAST &&
            s_axi_araddr[1:0] == 2'b00)
          rd_word = {16'h0,
            counter_preset[16*(s_axi_araddr[5:2]) +: 16]};
        else
          rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      ctrl         <= `CTRL_RESET;
      status       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      // A flag raised in the clearing cycle stays set.
      status <= (status & ~status_clr) | status_set;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `RESP_OKAY;
        if (s_axi_awaddr == `REG_CTRL) begin
          if (s_axi_wstrb[0])
            ctrl <= s_axi_wdata[1:0];
        end else if (s_axi_awaddr != `REG_STATUS)
          s_axi_bresp <= `RESP_SLVERR;
      end else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule // settings_download_command_parser

`default_nettype wire

/* File: src/settings_parser_map.vh */
/*
 * Constants for the settings download command parser: frame byte
 * positions, command codes, limits and register offsets.
 * Assumes it is included by its bare name from the design file.
 */
`ifndef SETTINGS_PARSER_MAP_VH
`define SETTINGS_PARSER_MAP_VH

// ****************************************************************
// Command codes
// ****************************************************************
`define CMD_FAMILY        4'ha
`define SUB_REPEAT        4'h0
`define SUB_COMMS         4'h1
`define SUB_COUNTERS      4'h2

// ****************************************************************
// Frame byte indices, index = (row - 1) * 3 + (column - 1)
// ****************************************************************
`define POS_CMD           6'd5
`define POS_ADDR_HI       6
`define POS_ADDR_LO       7
`define POS_PORT0         8
`define POS_TIMECODE      11
`define POS_AUX0          14
`define POS_AUX_MODE      24
`define POS_CNT0          6
`define COMMS_LAST        6'd29
`define COUNTERS_LAST     6'd47
`define N_PORTS           3
`define N_AUX             10
`define N_COUNTERS        15
`define FIRST_VARIANT_CNT 11
`define PRESET_MAX        16'd9999

// ****************************************************************
// Port configuration byte fields
// ****************************************************************
`define CFG_RATE_HI       3
`define CFG_RATE_LO       0
`define CFG_PAR_HI        5
`define CFG_PAR_LO        4
`define CFG_DATA_BIT      6
`define CFG_STOP_BIT      7
`define TC_DISABLE        8'h00
`define TC_CENTI          8'h01
`define TC_MILLI          8'h02

// ****************************************************************
// Register offsets (byte addresses) and bits
// ****************************************************************
`define REG_CTRL          8'h00
`define REG_STATUS        8'h04
`define REG_PASSWORD      8'h08
`define REG_CHECKSUM      8'h0c
`define REG_UNIT_ADDR     8'h10
`define REG_PORT_CFG      8'h14
`define REG_AUX_MODE      8'h18
`define REG_AUX0          8'h1c
`define REG_AUX1          8'h20
`define REG_AUX2          8'h24
`define REG_CNT_BASE      8'h40
`define REG_CNT_LAST      8'h78
`define CTRL_RESET        2'b01
`define ST_COMMS          0
`define ST_COUNTERS       1
`define ST_REJECT         2
`define ST_UNKNOWN        3
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

/* File: testbench/parser_monitor.sv */
/*
 * Checker for the settings download command parser outputs.
 * Assumes it is bound to every parser instance and sees its ports.
 */
`timescale 1ns/1ps
`default_nettype none
`include "settings_parser_map.vh"

module parser_monitor (
  // Clock and control
  input wire logic                      clk_sys,
  input wire logic                      rst_b,
  input wire logic                      clk_en,
  // Decoded settings
  input wire logic [15:0]               unit_address,
  input wire logic [16*`N_PORTS-1:0]    port_baud,
  input wire logic [2*`N_PORTS-1:0]     port_parity,
  input wire logic [`N_PORTS-1:0]       port_eight_bits,
  input wire logic [`N_PORTS-1:0]       port_two_stop,
  input wire logic                      timecode_enable,
  input wire logic                      timecode_centisecond_mode,
  input wire logic                      comms_load,
  input wire logic [16*`N_COUNTERS-1:0] counter_preset,
  input wire logic                      counter_load
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  logic preset_ok;
  logic baud_ok;

  // Codes 7 to 15 read back as zero, so zero counts as a legal rate.
  always_comb begin
    preset_ok = 1'b1;
    baud_ok = 1'b1;
    for (int i = 0; i < `N_COUNTERS; i++) begin
      if (counter_preset[16*i +: 16] > `PRESET_MAX) preset_ok = 1'b0;
    end
    for (int g = 0; g < `N_PORTS; g++) begin
      if (!(port_baud[16*g +: 16] inside {16'h0000, 16'h012c, 16'h04b0,
          16'h0960, 16'h12c0, 16'h2580, 16'h4b00, 16'h9600}))
        baud_ok = 1'b0;
    end
  end

  AST_LOAD_EXCL: assert property (!(comms_load && counter_load))
    else $error("both load pulses high together");
  AST_COMMS_PULSE: assert property (comms_load && clk_en |=> !comms_load)
    else $error("comms load pulse longer than one cycle");
  AST_COUNTER_PULSE: assert property (counter_load && clk_en |=> !counter_load)
    else $error("counter load pulse longer than one cycle");
  AST_ADDR_HOLD: assert property ($changed(unit_address) |-> comms_load)
    else $error("unit address moved without a commit");
  AST_PORT_HOLD: assert property ($changed({port_baud, port_parity,
      port_eight_bits, port_two_stop}) |-> comms_load)
    else $error("port settings moved without a commit");
  AST_PRESET_HOLD: assert property ($changed(counter_preset) |-> counter_load)
    else $error("counter presets moved without a load");
  AST_PRESET_RANGE: assert property (counter_load |-> preset_ok)
    else $error("counter preset above limit was loaded");
  AST_TC_MODE: assert property (timecode_centisecond_mode |-> timecode_enable)
    else $error("centisecond mode while time code disabled");
  AST_BAUD_LEGAL: assert property (comms_load |-> baud_ok)
    else $error("line rate outside the legal set");
endmodule // parser_monitor

bind settings_download_command_parser parser_monitor parser_monitor_inst (
  .clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
  .unit_address(unit_address), .port_baud(port_baud),
  .port_parity(port_parity), .port_eight_bits(port_eight_bits),
  .port_two_stop(port_two_stop), .timecode_enable(timecode_enable),
  .timecode_centisecond_mode(timecode_centisecond_mode),
  .comms_load(comms_load), .counter_preset(counter_preset),
  .counter_load(counter_load));

`default_nettype wire

/* File: testbench/remote_master_model.sv */
/*
 * Model of the remote master station: streams one frame of bytes.
 * Assumes clk_sys from the bench and a caller that starts after an edge.
 */
`timescale 1ns/1ps
`default_nettype none

module remote_master_model (
  // Clock
  input  wire logic       clk_sys,
  // Byte stream
  input  wire logic       rx_ready,
  output var  logic [7:0] rx_data,
  output var  logic       rx_first,
  output var  logic       rx_valid
);
  initial begin
    rx_data = 8'h00;
    rx_first = 1'b0;
    rx_valid = 1'b0;
  end

  // Ready only moves on rising edges, so the falling edge sees it settled.
  // Password leads, fields go high byte first, checksum closes.
  task automatic send(input logic [7:0] f [0:47], input int n,
                      input int gap, output bit ok);
    bit r;
    int w;
    ok = 1'b1;
    for (int i = 0; i < n; i++) begin
      rx_data <= f[i];
      rx_first <= (i == 0);
      rx_valid <= 1'b1;
      w = 0;
      do begin
        @(negedge clk_sys);
        r = rx_ready;
        @(posedge clk_sys);
        w++;
      end while (!r && w < 80);
      if (!r) ok = 1'b0;
      // Released data shows the inverse of the last byte.
      if (gap > 0 || i == n - 1) begin
        rx_valid <= 1'b0;
        rx_first <= 1'b0;
        rx_data <= ~f[i];
        repeat (gap) @(posedge clk_sys);
      end
    end
  endtask
endmodule // remote_master_model

`default_nettype wire

/* File: testbench/settings_download_command_parser_bench.sv */
/*
 * Bench for the settings download command parser.
 * Assumes the master model and the bound checker are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "settings_parser_map.vh"

module settings_download_command_parser_bench;
  logic         clk_sys, rst_b, clk_en, rx_first, rx_valid, rx_ready;
  logic [7:0]   rx_data, aux_mode_enable, s_axi_awaddr, s_axi_araddr;
  logic [15:0]  unit_address;
  logic [47:0]  port_baud;
  logic [5:0]   port_parity;
  logic [2:0]   port_eight_bits, port_two_stop;
  logic         timecode_enable, timecode_centisecond_mode, comms_load;
  logic [79:0]  aux_param;
  logic [239:0] counter_preset;
  logic         counter_load, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic         s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic         s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0]  s_axi_wdata, s_axi_rdata;
  logic [3:0]   s_axi_wstrb;
  logic [1:0]   s_axi_bresp, s_axi_rresp;
  logic [7:0]   f [0:47];
  logic [15:0]  cv [0:14];
  int           errors = 0, samples_checked = 0, n_comms = 0, n_cnt = 0;

  settings_download_command_parser settings_download_command_parser_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en), .rx_data(rx_data),
    .rx_first(rx_first), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .unit_address(unit_address), .port_baud(port_baud),
    .port_parity(port_parity), .port_eight_bits(port_eight_bits),
    .port_two_stop(port_two_stop), .timecode_enable(timecode_enable),
    .timecode_centisecond_mode(timecode_centisecond_mode),
    .aux_param(aux_param), .aux_mode_enable(aux_mode_enable),
    .comms_load(comms_load), .counter_preset(counter_preset),
    .counter_load(counter_load), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  remote_master_model remote_master_model_inst (
    .clk_sys(clk_sys), .rx_ready(rx_ready), .rx_data(rx_data),
    .rx_first(rx_first), .rx_valid(rx_valid));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (comms_load === 1'b1) n_comms <= n_comms + 1;
    if (counter_load === 1'b1) n_cnt <= n_cnt + 1;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic give_verdict;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic hs(input int k);
    case (k)
      0: hs = s_axi_awready & s_axi_wready;
      1: hs = s_axi_bvalid;
      2: hs = s_axi_arready;
      default: hs = s_axi_rvalid;
    endcase
  endfunction

  // Returns at a falling edge with the handshake high.
  task automatic wait_hi(input int k);
    int w;
    w = 0;
    @(negedge clk_sys);
    while (hs(k) !== 1'b1) begin
      w++;
      if (w > 60) begin
        errors++;
        give_verdict;
      end
      @(negedge clk_sys);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    wait_hi(0);
    @(posedge clk_sys);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    wait_hi(1);
    check(s_axi_bresp, `RESP_OKAY);
    @(posedge clk_sys);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    wait_hi(2);
    @(posedge clk_sys);
    s_axi_arvalid <= 1'b0;
    wait_hi(3);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge clk_sys);
  endtask

  task automatic frame_head(input logic [7:0] cmd, input int k);
    foreach (f[i]) f[i] = 8'hff;
    f[0] = 8'h5a;
    f[1] = 8'h3c;
    f[2] = 8'h0f;
    f[3] = 8'(k);
    f[5] = cmd;
  endtask

  // Commit lands within three edges of the last byte, so six is ample.
  task automatic send(input int n, input int gap);
    bit ok;
    remote_master_model_inst.send(f, n, gap, ok);
    if (!ok) begin
      errors++;
      give_verdict;
    end
    repeat (6) @(posedge clk_sys);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_comms;
    logic [15:0] rate [0:6] = '{16'h012c, 16'h04b0, 16'h0960, 16'h12c0,
                                16'h2580, 16'h4b00, 16'h9600};
    logic [31:0] d;
    logic [1:0]  r;
    for (int k = 0; k < 3; k++) begin
      frame_head(8'ha1, k);
      f[6] = 8'hc3;
      f[7] = 8'(k);
      for (int g = 0; g < 3; g++)
        f[8+g] = {g == 1, 1'((k+g)%2), 2'((k+g)%3), 4'((3*k+g)%7)};
      f[11] = 8'(k);
      for (int j = 0; j < 10; j++) f[14+j] = 8'(17*j + k);
      f[24] = 8'h81 << k;
      send(30, k);
      check(n_comms, k + 1);
      check(unit_address, {8'hc3, 8'(k)});
      for (int g = 0; g < 3; g++) begin
        check(port_baud[16*g +: 16], rate[(3*k+g)%7]);
        check(port_parity[2*g +: 2], f[8+g][5:4]);
        check(port_eight_bits[g], f[8+g][6]);
        check(port_two_stop[g], f[8+g][7]);
      end
      check({timecode_enable, timecode_centisecond_mode},
            {k != 0, k == 1});
      for (int j = 0; j < 10; j++) check(aux_param[8*j +: 8], f[14+j]);
      check(aux_mode_enable, f[24]);
      axi_rd(`REG_PASSWORD, d, r);
      check(d, {24'h5a3c0f, 8'(k)});
    end
  endtask

  task automatic test_counters(input int bad);
    logic [15:0] v;
    logic [31:0] d;
    logic [1:0]  r;
    frame_head(8'ha2, 0);
    for (int i = 0; i < 15; i++) begin
      v = (i == 0) ? 16'h270f : 16'(i * 613 + bad);
      if (i == 5 && bad == 1) v = 16'h2710;
      f[6+2*i] = v[15:8];
      f[7+2*i] = v[7:0];
      if (!bad || bad > 1 && i < 11) cv[i] = v;
    end
    send(48, 1);
    check(n_cnt, 1 + bad / 2);
    for (int i = 0; i < 15; i++)
      check(counter_preset[16*i +: 16], cv[i]);
    axi_rd(`REG_STATUS, d, r);
    check(d, bad ? 32'h7 : 32'h3);
  endtask

  task automatic test_bad_cmd;
    logic [7:0]  code [0:2] = '{8'ha0, 8'ha3, 8'ha4};
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 3; i++) begin
      frame_head(code[i], 0);
      send(30, 0);
      check(n_comms * 16 + n_cnt, 32'h32);
    end
    axi_rd(`REG_STATUS, d, r);
    check(d, 32'hf);
    axi_wr(`REG_STATUS, 32'hf);
    axi_rd(`REG_STATUS, d, r);
    check(d, 32'h0);
    axi_rd(8'h30, d, r);
    check(r, `RESP_SLVERR);
  endtask

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    rst_b = 1'b0;
    clk_en = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    axi_rd(`REG_CTRL, d, r);
    check(d, 32'h1);
    check(unit_address, 16'h0000);
    test_comms;
    axi_wr(`REG_CTRL, 32'h3);
    test_counters(0);
    test_counters(1);
    axi_wr(`REG_CTRL, 32'h1);
    test_counters(2);
    test_bad_cmd;
    give_verdict;
  end
endmodule // settings_download_command_parser_bench

`default_nettype wire
